// ### rtl/srp_regbank.sv
// Function
// - The converter drive polarity bit of the switch control register is read-only and host writes leave it unchanged.
// - Bit 6 of the converter period register always reads one and host writes cannot alter it.
// - With that bit held at one the converter period falls into a low range for bipolar and a high range for field-effect switches.
// - The external battery select bit of the converter battery register no longer exists and reads zero.
// - The PLL power-down bit cannot be written, so the PLL is never powered down.
// - A 4-bit read-only silicon revision field identifies the die revision.
// - The enhancement enable register holds eight separate enhancement enable bits.
// - The default calibration settling time is 300 ms.
// - A converter calibration targets the high-battery setting held at the moment it starts.
// - With automatic ring trip enabled a ring trip detected while the line state is ringing moves the line state to off-hook on its own.
// - The overhead range comes from bit 4 of the battery register and its value from the minimum overhead register.
// - The line capacitance compensation bits are functional and drive the line feed.
// - Daisy-chain operation does not depend on the serial mode bit.
// - The feedforward output is the inverse of the drive output on the standard variant and equal on the alternate from the first clock after reset.
// - An FSK data register, a loop closure debounce register and a loop closure lower threshold register exist.
`timescale 1ns/1ps
`default_nettype none
module srp_regbank
    import srp_pkg::*;
#(
    parameter logic [3:0]  REVISION       = REVISION_DEFAULT,
    parameter logic        ALT_VARIANT    = 1'b0,
    parameter int unsigned CAL_SETTLE_CYCLES = CAL_SETTLE_CYC
) (
    // apb slave
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output var  logic [31:0]       prdata,
    output var  logic              pready,
    output var  logic              pslverr,
    // line events
    input  wire logic              ring_trip_in,
    // converter pins
    output var  logic              converter_drive_out,
    output var  logic              converter_feedforward_out,
    // line feed controls
    output var  logic [7:0]        line_cap_compensation,
    output var  logic              overhead_range_select,
    output var  logic [15:0]       min_overhead_voltage,
    output var  logic [15:0]       loop_closure_lower_threshold,
    output var  logic [7:0]        fsk_data,
    output var  logic [7:0]        loop_closure_debounce,
    output var  logic [7:0]        enhancement_enable,
    output var  logic              serial_mode_select,
    output var  logic              pll_power_down,
    output var  logic [LS_W-1:0]   line_state,
    // calibration
    output var  logic              cal_busy,
    output var  logic [7:0]        cal_target_voltage,
    // interrupt
    output var  logic              irq
);

    localparam int unsigned CNT_W = $clog2(CAL_SETTLE_CYCLES + 1);

    // storage
    logic [7:0]       serial_cfg_r;
    logic [7:0]       line_cap_r;
    logic [7:0]       pll_r;
    logic [7:0]       fsk_r;
    logic [7:0]       lc_debounce_r;
    logic [7:0]       conv_bat_r;
    logic [7:0]       high_battery_voltage_r;
    logic [7:0]       conv_period_r;
    logic [7:0]       conv_switch_r;
    logic [7:0]       enhance_r;
    logic [15:0]      min_ov_r;
    logic [15:0]      lc_lower_r;

    logic [LS_W-1:0]  line_state_r;
    logic [LS_W-1:0]  line_state_nxt;
    logic             auto_rt_r;

    logic [IRQ_W-1:0] irq_status_r;
    logic [IRQ_W-1:0] irq_status_nxt;
    logic [IRQ_W-1:0] irq_mask_r;
    logic [IRQ_W-1:0] irq_event;

    // apb decode
    logic [7:0]  idx;
    logic        access;
    logic        wr_en;
    logic        rd_capture;
    logic        hit;
    logic [31:0] rd_data;

    logic [7:0]  wbyte;
    logic [15:0] whalf;

    // writes commit with pready
    assign idx        = paddr[9:2];
    assign access     = psel & penable;
    assign wr_en      = access & pwrite & pready;
    assign rd_capture = access & ~pready;
    assign wbyte      = pwdata[7:0];
    assign whalf      = pwdata[15:0];

    logic we_serial, we_line_cap, we_pll, we_fsk, we_lc_deb, we_conv_bat;
    logic we_high_battery_voltage, we_period, we_switch, we_enhance, we_min_ov;
    logic we_lc_lower, we_line_state, we_cal, we_irq_status, we_irq_mask;

    assign we_serial     = wr_en & (idx == IDX_SERIAL_CFG);
    assign we_line_cap   = wr_en & (idx == IDX_LINE_CAP);
    assign we_pll        = wr_en & (idx == IDX_PLL);
    assign we_fsk        = wr_en & (idx == IDX_FSK);
    assign we_lc_deb     = wr_en & (idx == IDX_LC_DEBOUNCE);
    assign we_conv_bat   = wr_en & (idx == IDX_CONV_BAT);
    assign we_high_battery_voltage      = wr_en & (idx == IDX_HIGH_BATTERY_VOLTAGE);
    assign we_period     = wr_en & (idx == IDX_CONV_PERIOD);
    assign we_switch     = wr_en & (idx == IDX_CONV_SWITCH);
    assign we_enhance    = wr_en & (idx == IDX_ENHANCE);
    assign we_min_ov     = wr_en & (idx == IDX_MIN_OV);
    assign we_lc_lower   = wr_en & (idx == IDX_LC_LOWER);
    assign we_line_state = wr_en & (idx == IDX_LINE_STATE);
    assign we_cal        = wr_en & (idx == IDX_CAL);
    assign we_irq_status = wr_en & (idx == IDX_IRQ_STATUS);
    assign we_irq_mask   = wr_en & (idx == IDX_IRQ_MASK);

    // ring trip pin synchroniser and edge detect
    logic rt_meta_r, rt_sync_r, rt_prev_r;
    logic ring_trip_rise;

    assign ring_trip_rise = rt_sync_r & ~rt_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rt_meta_r <= 1'b0;
            rt_sync_r <= 1'b0;
            rt_prev_r <= 1'b0;
        end else begin
            rt_meta_r <= ring_trip_in;
            rt_sync_r <= rt_meta_r;
            rt_prev_r <= rt_sync_r;
        end
    end

    // calibration sequencer
    srp_cal_state_t   cal_state_r;
    logic [CNT_W-1:0] cal_cnt_r;
    logic [7:0]       cal_target_r;
    logic             cal_start;
    logic             cal_done;

    // a restart while busy is dropped
    assign cal_start = we_cal & wbyte[CAL_START_BIT] &
                       (cal_state_r == CAL_IDLE);
    assign cal_done  = (cal_state_r == CAL_SETTLE) &&
                       (cal_cnt_r == CNT_W'(CAL_SETTLE_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_state_r  <= CAL_IDLE;
            cal_cnt_r    <= '0;
            cal_target_r <= RST_BYTE;
        end else begin
            unique case (cal_state_r)
                CAL_IDLE: begin
                    cal_cnt_r <= '0;
                    if (cal_start) begin
                        cal_target_r <= high_battery_voltage_r;
                        cal_state_r  <= CAL_SETTLE;
                    end
                end
                CAL_SETTLE: begin
                    cal_cnt_r <= cal_cnt_r + CNT_W'(1);
                    if (cal_done) begin
                        cal_state_r <= CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // automatic ring trip to off-hook; hardware wins over a host write
    logic auto_offhook;

    assign auto_offhook = ring_trip_rise & auto_rt_r &
                          (line_state_r == LS_RINGING);
    assign line_state_nxt = auto_offhook ? LS_ACTIVE :
                            we_line_state ? wbyte[LS_W-1:0] : line_state_r;

    // sticky status, set wins over write-one-to-clear
    always_comb begin
        irq_event                 = '0;

        irq_event[IRQ_RING_TRIP]  = ring_trip_rise;
        irq_event[IRQ_AUTO_OFFHK] = auto_offhook;
        irq_event[IRQ_CAL_DONE]   = cal_done;
    end

    assign irq_status_nxt = irq_event |
        (irq_status_r & ~(we_irq_status ? pwdata[IRQ_W-1:0] : '0));

    // register storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_cfg_r  <= RST_BYTE;
            line_cap_r    <= RST_BYTE;
            pll_r         <= RST_BYTE;
            fsk_r         <= RST_BYTE;
            lc_debounce_r <= RST_BYTE;
            conv_bat_r    <= RST_BYTE;
            high_battery_voltage_r       <= RST_BYTE;
            conv_period_r <= RST_PERIOD;
            conv_switch_r <= RST_BYTE;
            enhance_r     <= RST_BYTE;
            min_ov_r      <= RST_HALF;
            lc_lower_r    <= RST_HALF;
            line_state_r  <= LS_OPEN;
            auto_rt_r     <= 1'b0;
            irq_status_r  <= '0;
            irq_mask_r    <= '0;
        end else begin
            // serial mode bit stored and driven to serial_mode_select, daisy chain ignores it
            if (we_serial)   serial_cfg_r  <= wbyte;
            if (we_line_cap) line_cap_r    <= wbyte;
            if (we_pll)      pll_r         <= wbyte & PLL_WMASK;
            if (we_fsk)      fsk_r         <= wbyte;
            if (we_lc_deb)   lc_debounce_r <= wbyte;
            if (we_conv_bat) conv_bat_r    <= wbyte & CONV_BAT_WMASK;
            if (we_high_battery_voltage)    high_battery_voltage_r       <= wbyte;
            if (we_period)   conv_period_r <= (wbyte & PERIOD_WMASK)
                                              | ~PERIOD_WMASK;
            if (we_switch)   conv_switch_r <= wbyte & SWITCH_WMASK;
            if (we_enhance)  enhance_r     <= wbyte;
            if (we_min_ov)   min_ov_r      <= whalf;
            if (we_lc_lower) lc_lower_r    <= whalf;
            if (we_line_state) auto_rt_r   <= wbyte[AUTO_RT_BIT];
            if (we_irq_mask) irq_mask_r    <= pwdata[IRQ_W-1:0];

            line_state_r <= line_state_nxt;
            irq_status_r <= irq_status_nxt;
        end
    end

    // read mux; protected bits read their fixed values
    logic [7:0] switch_view;

    assign switch_view = (conv_switch_r & SWITCH_WMASK) |
                         (ALT_VARIANT ? ~SWITCH_WMASK : 8'h00);

    always_comb begin
        rd_data = 32'h0000_0000;
        hit     = 1'b1;

        unique case (idx)
            IDX_SERIAL_CFG:  rd_data[7:0]  = serial_cfg_r;
            IDX_LINE_CAP:    rd_data[7:0]  = line_cap_r;
            IDX_PLL:         rd_data[7:0]  = pll_r & PLL_WMASK;
            IDX_FSK:         rd_data[7:0]  = fsk_r;
            IDX_LC_DEBOUNCE: rd_data[7:0]  = lc_debounce_r;
            IDX_CONV_BAT:    rd_data[7:0]  = conv_bat_r & CONV_BAT_WMASK;
            IDX_HIGH_BATTERY_VOLTAGE:       rd_data[7:0]  = high_battery_voltage_r;
            IDX_CONV_PERIOD: rd_data[7:0]  = conv_period_r | ~PERIOD_WMASK;
            IDX_CONV_SWITCH: rd_data[7:0]  = switch_view;
            IDX_ENHANCE:     rd_data[7:0]  = enhance_r;
            IDX_MIN_OV:      rd_data[15:0] = min_ov_r;
            IDX_LC_LOWER:    rd_data[15:0] = lc_lower_r;
            IDX_REVISION:    rd_data[3:0]  = REVISION;
            IDX_LINE_STATE: begin
                rd_data[LS_W-1:0]   = line_state_r;
                rd_data[AUTO_RT_BIT] = auto_rt_r;
            end
            IDX_CAL:         rd_data[CAL_START_BIT] =
                                 (cal_state_r == CAL_SETTLE);
            IDX_IRQ_STATUS:  rd_data[IRQ_W-1:0] = irq_status_r;
            IDX_IRQ_MASK:    rd_data[IRQ_W-1:0] = irq_mask_r;
            default:         hit = 1'b0;
        endcase
    end

    // one wait state; protected-bit writes still complete without error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= rd_capture;
            if (rd_capture) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_data;
                pslverr <= ~hit;
            end
        end
    end

    // outputs straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_cap_compensation        <= RST_BYTE;
            overhead_range_select        <= 1'b0;
            min_overhead_voltage         <= RST_HALF;
            loop_closure_lower_threshold <= RST_HALF;
            fsk_data                     <= RST_BYTE;
            loop_closure_debounce        <= RST_BYTE;
            enhancement_enable           <= RST_BYTE;
            serial_mode_select           <= 1'b0;
            pll_power_down               <= 1'b0;
            line_state                   <= LS_OPEN;
            cal_busy                     <= 1'b0;
            cal_target_voltage           <= RST_BYTE;
            irq                          <= 1'b0;
        end else begin
            line_cap_compensation        <= line_cap_r;
            overhead_range_select        <= conv_bat_r[OVERHEAD_RANGE_BIT];
            min_overhead_voltage         <= min_ov_r;
            loop_closure_lower_threshold <= lc_lower_r;
            fsk_data                     <= fsk_r;
            loop_closure_debounce        <= lc_debounce_r;
            enhancement_enable           <= enhance_r;
            serial_mode_select           <= serial_cfg_r[SERIAL_MODE_BIT];
            pll_power_down               <= pll_r[PLL_DOWN_BIT];
            line_state                   <= line_state_r;
            cal_busy                     <= (cal_state_r == CAL_SETTLE);
            cal_target_voltage           <= cal_target_r;
            irq                          <= |(irq_status_nxt & irq_mask_r);
        end
    end

    // converter drive; fixed period bit keeps the two frequency ranges
    srp_dcdc_cfg_t dcdc_cfg;

    assign dcdc_cfg.period        = conv_period_r | ~PERIOD_WMASK;
    assign dcdc_cfg.same_polarity = ALT_VARIANT;

    srp_dcdc_pwm u_pwm (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .cfg                       (dcdc_cfg),
        .converter_drive_out       (converter_drive_out),
        .converter_feedforward_out (converter_feedforward_out)
    );

endmodule // srp_regbank
`default_nettype wire

// ### rtl/srp_pkg.sv
package srp_pkg;

    // register indices; byte address is four times the index
    localparam int unsigned ADDR_W = 10;
    localparam logic [7:0] IDX_SERIAL_CFG  = 8'h00;
    localparam logic [7:0] IDX_LINE_CAP    = 8'h0A;
    localparam logic [7:0] IDX_PLL         = 8'h0E;
    localparam logic [7:0] IDX_FSK         = 8'h34;
    localparam logic [7:0] IDX_LC_DEBOUNCE = 8'h3F;
    localparam logic [7:0] IDX_CONV_BAT    = 8'h42;
    localparam logic [7:0] IDX_HIGH_BATTERY_VOLTAGE       = 8'h4A;
    localparam logic [7:0] IDX_CONV_PERIOD = 8'h5C;
    localparam logic [7:0] IDX_CONV_SWITCH = 8'h5D;
    localparam logic [7:0] IDX_ENHANCE     = 8'h6C;
    localparam logic [7:0] IDX_MIN_OV      = 8'h70;
    localparam logic [7:0] IDX_LC_LOWER    = 8'h71;
    localparam logic [7:0] IDX_REVISION    = 8'h72;
    localparam logic [7:0] IDX_LINE_STATE  = 8'h73;
    localparam logic [7:0] IDX_CAL         = 8'h74;
    localparam logic [7:0] IDX_IRQ_STATUS  = 8'h75;
    localparam logic [7:0] IDX_IRQ_MASK    = 8'h76;

    // field positions
    localparam int unsigned SERIAL_MODE_BIT    = 6;
    localparam int unsigned PLL_DOWN_BIT       = 0;
    localparam int unsigned EXT_BAT_BIT        = 2;
    localparam int unsigned OVERHEAD_RANGE_BIT = 4;
    localparam int unsigned PERIOD_FIXED_BIT   = 6;
    localparam int unsigned DRIVE_POL_BIT      = 5;
    localparam int unsigned AUTO_RT_BIT        = 4;
    localparam int unsigned CAL_START_BIT      = 0;

    // bits that host writes may change
    localparam logic [7:0] PLL_WMASK      = 8'hFE;
    localparam logic [7:0] CONV_BAT_WMASK = 8'hFB;
    localparam logic [7:0] PERIOD_WMASK   = 8'hBF;
    localparam logic [7:0] SWITCH_WMASK   = 8'hDF;

    // reset values
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_HALF   = 16'h0000;
    localparam logic [7:0]  RST_PERIOD = 8'h40;

    // line states
    localparam int unsigned LS_W = 3;
    localparam logic [2:0] LS_OPEN    = 3'h0;
    localparam logic [2:0] LS_ACTIVE  = 3'h1;
    localparam logic [2:0] LS_RINGING = 3'h4;

    // interrupt status bits
    localparam int unsigned IRQ_W          = 3;
    localparam int unsigned IRQ_RING_TRIP  = 0;
    localparam int unsigned IRQ_AUTO_OFFHK = 1;
    localparam int unsigned IRQ_CAL_DONE   = 2;

    // timing
    localparam int unsigned CLK_HZ       = 10_000_000;
    localparam int unsigned CAL_SETTLE_MS = 300;
    localparam int unsigned CAL_SETTLE_CYC =
        CAL_SETTLE_MS * (CLK_HZ / 1000);

    // revision field, value arbitrary
    localparam logic [3:0] REVISION_DEFAULT = 4'hA;

    typedef enum logic [0:0] {
        CAL_IDLE   = 1'b0,
        CAL_SETTLE = 1'b1
    } srp_cal_state_t;

    typedef struct packed {
        logic [7:0] period;
        logic       same_polarity;
    } srp_dcdc_cfg_t;

endpackage

// ### rtl/srp_dcdc_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module srp_dcdc_pwm
    import srp_pkg::*;
(
    // clock and reset
    input  wire logic          pclk,
    input  wire logic          presetn,
    // configuration
    input  wire srp_dcdc_cfg_t cfg,
    // pins
    output var  logic          converter_drive_out,
    output var  logic          converter_feedforward_out
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       wrap;
    logic       drive_nxt;

    // period never drops below 64 steps, the fixed bit sees to that
    assign wrap      = (cnt_r >= cfg.period);
    assign cnt_nxt   = wrap ? 8'h00 : cnt_r + 8'h01;
    assign drive_nxt = (cnt_nxt < {1'b0, cfg.period[7:1]});

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r                     <= 8'h00;
            converter_drive_out       <= 1'b0;
            converter_feedforward_out <= 1'b1;
        end else begin
            cnt_r                     <= cnt_nxt;
            converter_drive_out       <= drive_nxt;
            converter_feedforward_out <= drive_nxt ^ ~cfg.same_polarity;
        end
    end

endmodule // srp_dcdc_pwm
`default_nettype wire

// ### verif/srp_regbank_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module srp_regbank_asserts
    import srp_pkg::*;
#(
    parameter logic ALT_VARIANT = 1'b0
) (
    // apb
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // watched outputs
    input wire logic              converter_drive_out,
    input wire logic              converter_feedforward_out,
    input wire logic [7:0]        line_cap_compensation,
    input wire logic              overhead_range_select,
    input wire logic              serial_mode_select,
    input wire logic              pll_power_down,
    input wire logic              cal_busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [7:0] idx = paddr[9:2];
    wire logic mapped = idx inside {IDX_SERIAL_CFG, IDX_LINE_CAP, IDX_PLL,
        IDX_FSK, IDX_LC_DEBOUNCE, IDX_CONV_BAT, IDX_HIGH_BATTERY_VOLTAGE, IDX_CONV_PERIOD,
        IDX_CONV_SWITCH, IDX_ENHANCE, IDX_MIN_OV, IDX_LC_LOWER,
        IDX_REVISION, IDX_LINE_STATE, IDX_CAL, IDX_IRQ_STATUS, IDX_IRQ_MASK};
    sequence acc_wait;
        psel && penable && !pready;
    endsequence
    sequence wr_done(logic [7:0] i);
        psel && penable && pready && pwrite && idx == i;
    endsequence
    sequence cal_start;
        wr_done(IDX_CAL) ##0 (pwdata[CAL_START_BIT] && !cal_busy);
    endsequence
    a_pready_wait: assert property (acc_wait |=> pready)
        else $error("no answer after one wait state");
    a_pready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_error_only_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    a_pll_stays_up: assert property (!pll_power_down)
        else $error("pll power down asserted");
    a_ff_polarity: assert property (converter_feedforward_out ==
        (ALT_VARIANT ? converter_drive_out : !converter_drive_out))
        else $error("feedforward polarity wrong");
    a_serial_mode: assert property (wr_done(IDX_SERIAL_CFG) |-> ##2
        serial_mode_select == $past(pwdata[SERIAL_MODE_BIT], 2))
        else $error("serial mode output not updated");
    a_overhead_range: assert property (wr_done(IDX_CONV_BAT) |-> ##2
        overhead_range_select == $past(pwdata[OVERHEAD_RANGE_BIT], 2))
        else $error("overhead range output not updated");
    a_line_cap: assert property (wr_done(IDX_LINE_CAP) |-> ##2
        line_cap_compensation == $past(pwdata[7:0], 2))
        else $error("line cap output not updated");
    a_cal_busy_rise: assert property (cal_start |-> ##2 cal_busy)
        else $error("calibration did not start");
    a_cal_settle: assert property ($rose(cal_busy) |->
        cal_busy [*8] ##[1:40] !cal_busy)
        else $error("calibration settle length wrong");
endmodule // srp_regbank_asserts

bind srp_regbank srp_regbank_asserts #(.ALT_VARIANT(ALT_VARIANT)) i_asserts (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .converter_drive_out, .converter_feedforward_out,
    .line_cap_compensation, .overhead_range_select, .serial_mode_select,
    .pll_power_down, .cal_busy);
`default_nettype wire

// ### verif/srp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srp_host_model
    import srp_pkg::*;
(
    // clock
    input  wire logic              pclk,
    // apb master
    output var  logic              psel,
    output var  logic              penable,
    output var  logic              pwrite,
    output var  logic [ADDR_W-1:0] paddr,
    output var  logic [31:0]       pwdata,
    input  wire logic [31:0]       prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end
    // held until pready is sampled
    task automatic xfer(input logic wr, input logic [7:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err,
        output logic to);
        to = 1'b1;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (int n = 0; n < 16 && to; n++) begin
            @(posedge pclk);
            to = !pready;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released data must not keep looking valid
        pwdata <= ~wd;
    endtask
endmodule // srp_host_model
`default_nettype wire

// ### verif/slic_register_protection_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    miscompares++; $display("[FAIL] t=%0t got %0h exp %0h", $time, \
    (a), (b)); end end
module slic_register_protection_bench
    import srp_pkg::*;
;
    // revision value arbitrary
    localparam logic [3:0] BENCH_REV = 4'h9;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              ring_trip_in = 1'b0;
    logic              psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic              rerr, converter_drive_out, converter_feedforward_out;
    logic              overhead_range_select, serial_mode_select;
    logic              pll_power_down, cal_busy, irq;
    logic [7:0]        line_cap_compensation, fsk_data, cal_target_voltage;
    logic [7:0]        loop_closure_debounce, enhancement_enable;
    logic [15:0]       min_overhead_voltage, loop_closure_lower_threshold;
    logic [LS_W-1:0]   line_state;
    int                miscompares = 0;
    int                cmp_count = 0;
    always #50 pclk = ~pclk;
    srp_regbank #(.REVISION(BENCH_REV), .CAL_SETTLE_CYCLES(20)) i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ring_trip_in, .converter_drive_out,
        .converter_feedforward_out, .line_cap_compensation,
        .overhead_range_select, .min_overhead_voltage,
        .loop_closure_lower_threshold, .fsk_data, .loop_closure_debounce,
        .enhancement_enable, .serial_mode_select, .pll_power_down,
        .line_state, .cal_busy, .cal_target_voltage, .irq);
    srp_host_model i_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] i,
        input logic [31:0] d);
        logic to;
        i_host.xfer(w, i, d, rdat, rerr, to);
        if (to) begin
            miscompares++;
            end_sim();
        end
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        acc(1'b0, i, 32'h0);
        `CHK(rdat, e)
    endtask
    task automatic t_reset_values();
        rd(IDX_CONV_PERIOD, 32'h0000_0040);
        rd(IDX_PLL, 32'h0);
        rd(IDX_REVISION, {28'h0, BENCH_REV});
    endtask
    // ones, then zeros, at the guarded registers
    task automatic t_protected();
        logic [7:0] ri[4] = '{IDX_PLL, IDX_CONV_BAT, IDX_CONV_PERIOD,
            IDX_CONV_SWITCH};
        logic [7:0] keep[4] = '{8'hFE, 8'hFB, 8'hBF, 8'hDF};
        logic [7:0] pat;
        for (int p = 0; p < 2; p++) begin
            pat = p ? 8'h00 : 8'hFF;
            for (int k = 0; k < 4; k++) begin
                acc(1'b1, ri[k], {24'h0, pat});
                `CHK(rerr, 1'b0)
                rd(ri[k], {24'h0, pat & keep[k] | (k == 2 ? 8'h40 : 8'h0)});
            end
            `CHK(overhead_range_select, pat[4])
        end
    endtask
    task automatic t_plain_regs();
        acc(1'b1, IDX_LINE_CAP, 32'h5A);
        acc(1'b1, IDX_FSK, 32'hA5);
        acc(1'b1, IDX_LC_DEBOUNCE, 32'h3C);
        acc(1'b1, IDX_MIN_OV, 32'h1234);
        acc(1'b1, IDX_LC_LOWER, 32'hBEEF);
        acc(1'b1, IDX_SERIAL_CFG, 32'h40);
        rd(IDX_LC_LOWER, 32'hBEEF);
        `CHK(line_cap_compensation, 8'h5A)
        `CHK(fsk_data, 8'hA5)
        `CHK(loop_closure_debounce, 8'h3C)
        `CHK(min_overhead_voltage, 16'h1234)
        `CHK(loop_closure_lower_threshold, 16'hBEEF)
        `CHK(serial_mode_select, 1'b1)
        for (int b = 0; b < 8; b++) begin
            acc(1'b1, IDX_ENHANCE, 32'h1 << b);
            rd(IDX_ENHANCE, 32'h1 << b);
            `CHK(enhancement_enable, 8'h1 << b)
        end
        acc(1'b1, 8'h50, 32'hFFFF_FFFF);
        `CHK(rerr, 1'b1)
        rd(8'h50, 32'h0);
    endtask
    // disabled, then enabled: only the second moves
    task automatic t_ring_trip();
        acc(1'b1, IDX_IRQ_MASK, 32'h2);
        for (int e = 0; e < 2; e++) begin
            acc(1'b1, IDX_LINE_STATE, e ? 32'h14 : 32'h04);
            ring_trip_in <= 1'b1;
            repeat (8) @(posedge pclk);
            ring_trip_in <= 1'b0;
            `CHK(line_state, e ? LS_ACTIVE : LS_RINGING)
            `CHK(irq, e[0])
            rd(IDX_IRQ_STATUS, e ? 32'h3 : 32'h1);
            acc(1'b1, IDX_IRQ_STATUS, 32'h7);
            rd(IDX_IRQ_STATUS, 32'h0);
        end
    endtask
    task automatic t_calibration();
        realtime t0;
        acc(1'b1, IDX_HIGH_BATTERY_VOLTAGE, 32'h5A);
        acc(1'b1, IDX_IRQ_MASK, 32'h4);
        acc(1'b1, IDX_CAL, 32'h1);
        t0 = $realtime;
        // retarget and restart while busy: ignored
        acc(1'b1, IDX_HIGH_BATTERY_VOLTAGE, 32'h33);
        acc(1'b1, IDX_CAL, 32'h1);
        for (int n = 0; n < 100 && cal_busy !== 1'b0; n++) @(posedge pclk);
        `CHK(($realtime - t0) inside {[1900:2400]}, 1'b1)
        `CHK(cal_target_voltage, 8'h5A)
        @(posedge pclk);
        `CHK(irq, 1'b1)
        acc(1'b1, IDX_IRQ_STATUS, 32'h4);
        rd(IDX_IRQ_STATUS, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_reset_values();
        t_protected();
        t_plain_regs();
        t_ring_trip();
        t_calibration();
        end_sim();
    end
endmodule // slic_register_protection_bench
`default_nettype wire
